/* File: inc/timer_pwm_defines.svh */
`ifndef TIMER_PWM_DEFINES_SVH
`define TIMER_PWM_DEFINES_SVH
`define ADDR_W 12
`define OFS_CTRL 12'h000
`define OFS_LIMIT 12'h004
`define OFS_COUNT 12'h008
`define OFS_CH_CTRL 12'h010
`define OFS_CH_VALUE 12'h030
`define REG_STRIDE 12'h004
`define CTRL_FLAG 7
`define CTRL_STOP 5
`define CTRL_CLEAR 4
`define CTRL_PSEL_HI 2
`define CTRL_PSEL_LO 0
`define CH_FLAG 7
`define CH_ACTIVE 6
`define CH_MODE_HI 5
`define CH_MODE_LO 4
`define CH_ACT_HI 3
`define CH_ACT_LO 2
`define CH_TOGGLE 1
`define MODE_BUF_BIT 1
`define MODE_ONE_BIT 0
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3
`define LIMIT_RESET 16'hFFFF
`define STOP_RESET 1'b1
`define PSEL_RESET 3'h0
`endif

/* File: inc/timer_pwm_pkg.sv */
package timer_pwm_pkg;
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_SINGLE,
      MODE_BUFFERED
   } chanMode_t;
   typedef logic [31:0] word_t;
endpackage

/* File: inc/count_bus_if.sv */
`timescale 1ns/1ps
interface count_bus_if #(parameter int WIDTH = 16);
   logic tick;
   logic wrap;
   logic [WIDTH-1:0] nextCount;
   modport src (output tick, output wrap, output nextCount);
   modport chan (input tick, input wrap, input nextCount);
endinterface

/* File: logic/pwm_prescaler.sv */
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"
module pwm_prescaler #(
   parameter int SELW = 3
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   input wire logic [SELW-1:0] sel,
   output logic tick
);
   localparam int DW = (1 << SELW) - 1;
   logic [DW-1:0] div_q;
   logic [DW-1:0] mask;

   // Divides by two to the power of the select value.
   always_comb begin
      mask = DW'((1 << sel) - 1);
      tick = run && ((div_q & mask) == mask);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || clear) begin
         div_q <= '0;
      end else if (run) begin
         div_q <= div_q + DW'(1);
      end
   end
endmodule

/* File: logic/pwm_channel.sv */
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"
module pwm_channel #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   count_bus_if.chan bus,
   input timer_pwm_pkg::chanMode_t mode,
   input wire logic [1:0] action,
   input wire logic toggleOnWrap,
   input wire logic [WIDTH-1:0] value,
   output logic level,
   output logic matchEv
);
   logic level_q;

   // A compare happens as the counter steps onto the compare value.
   assign matchEv = (mode != timer_pwm_pkg::MODE_OFF) && bus.tick &&
      (bus.nextCount == value); // [R2] [R5]
   assign level = level_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         level_q <= 1'b0;
      end else if (matchEv && action != `ACT_NONE) begin
         case (action) // [R18]
            `ACT_TOGGLE: level_q <= ~level_q;
            `ACT_CLEAR: level_q <= 1'b0;
            default: level_q <= 1'b1;
         endcase
      end else if (mode != timer_pwm_pkg::MODE_OFF && bus.wrap &&
         toggleOnWrap) begin
         level_q <= ~level_q; // [R1]
      end
   end
endmodule

/* File: logic/timer_pwm_channels.sv */
// Overview of operation
// R1 - Overflow toggles pin when toggle bit set.
// R2 - Pulse spans overflow to compare match.
// R3 - Period is limit plus one prescaled counts.
// R4 - Value 128 over 256 gives half duty.
// R5 - Unbuffered value writes act at once.
// R6 - Software shortens pulse in compare handler.
// R7 - Software lengthens pulse in overflow handler.
// R8 - Software never toggles on compare for PWM.
// R9 - Buffered bit on even channel links pair.
// R10 - Last written member controls from next overflow.
// R11 - Even control register runs pair, odd unused.
// R12 - Buffered pair releases odd pin to GPIO.
// R13 - Software writes only the inactive member.
// R14 - Software stops then clears counter first.
// R15 - Software loads period then width.
// R16 - Mode field 0:1 unbuffered, 1:0 buffered.
// R17 - Software sets toggle-on-overflow bit.
// R18 - Pin action 1:0 clears, 1:1 sets.
// R19 - Stop bit holds counter, set by reset.
// R20 - Clear bit zeroes counter, prescaler; reads zero.
// R21 - Buffered bit wins over unbuffered bit.
// R22 - Counter wraps to zero after limit, flagging.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"
module timer_pwm_channels #(
   parameter int WIDTH = 16,
   parameter int CHANNELS = 6
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic [CHANNELS-1:0] chanPin,
   output logic [CHANNELS-1:0] chanPinOeN
);
   localparam int PAIRS = CHANNELS / 2;

   logic stop_q;
   logic flag_q;
   logic [2:0] prescaleSel_q;
   logic [WIDTH-1:0] limit_q;
   logic [WIDTH-1:0] count_q;
   logic [1:0] modeField_q [CHANNELS];
   logic [1:0] action_q [CHANNELS];
   logic [WIDTH-1:0] value_q [CHANNELS];
   logic [CHANNELS-1:0] toggle_q;
   logic [CHANNELS-1:0] chFlag_q;
   logic [PAIRS-1:0] lastOdd_q;
   logic [PAIRS-1:0] lastOdd_d;
   logic [PAIRS-1:0] activeOdd_q;
   logic [PAIRS-1:0] pairBuffered;

   logic access;
   logic wrEn;
   logic ctrlWr;
   logic clearPulse;
   logic tick;
   logic overflowEv;
   logic [WIDTH-1:0] nextCount;
   logic [31:0] rdData;
   logic rdHit;
   timer_pwm_pkg::chanMode_t chMode [CHANNELS];
   logic [WIDTH-1:0] chValue [CHANNELS];
   logic [CHANNELS-1:0] chLevel;
   logic [CHANNELS-1:0] chMatch;
   logic [CHANNELS-1:0] chValueWr;

   count_bus_if #(.WIDTH(WIDTH)) cbus ();

   // Matches a register of an indexed bank.
   function automatic logic regHit(input logic [`ADDR_W-1:0] addr,
      input logic [`ADDR_W-1:0] base, input int idx);
      regHit = (addr == base + `ADDR_W'(idx * `REG_STRIDE));
   endfunction

   // Works out the mode a channel really runs in.
   function automatic timer_pwm_pkg::chanMode_t decodeMode(
      input logic [1:0] field, input logic oddReleased);
      if (oddReleased) begin
         decodeMode = timer_pwm_pkg::MODE_OFF; // [R11]
      end else if (field[`MODE_BUF_BIT]) begin
         decodeMode = timer_pwm_pkg::MODE_BUFFERED; // [R16] [R21]
      end else if (field[`MODE_ONE_BIT]) begin
         decodeMode = timer_pwm_pkg::MODE_SINGLE; // [R16]
      end else begin
         decodeMode = timer_pwm_pkg::MODE_OFF;
      end
   endfunction

   assign access = psel && penable && pready;
   assign wrEn = access && pwrite;
   assign ctrlWr = wrEn && (paddr == `OFS_CTRL);
   assign clearPulse = ctrlWr && pwdata[`CTRL_CLEAR]; // [R20]

   pwm_prescaler #(.SELW(3)) prescaler (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(clearPulse),
      .run(!stop_q), // [R19]
      .sel(prescaleSel_q),
      .tick(tick)
   );

   // The period is limit plus one ticks of the prescaler.
   always_comb begin
      overflowEv = tick && !clearPulse && (count_q == limit_q); // [R22]
      if (overflowEv) begin
         nextCount = '0; // [R3] [R4]
      end else begin
         nextCount = count_q + WIDTH'(1);
      end
   end

   assign cbus.tick = tick && !clearPulse;
   assign cbus.wrap = overflowEv;
   assign cbus.nextCount = nextCount;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (clearPulse) begin
         count_q <= '0; // [R20]
      end else if (tick) begin
         count_q <= nextCount; // [R19] [R22]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stop_q <= `STOP_RESET; // [R19]
         prescaleSel_q <= `PSEL_RESET;
      end else if (ctrlWr) begin
         stop_q <= pwdata[`CTRL_STOP]; // [R19]
         prescaleSel_q <= pwdata[`CTRL_PSEL_HI:`CTRL_PSEL_LO];
      end
   end

   // A new overflow wins over a software clear in the same cycle.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (overflowEv) begin
         flag_q <= 1'b1; // [R22]
      end else if (ctrlWr && !pwdata[`CTRL_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         limit_q <= `LIMIT_RESET;
      end else if (wrEn && paddr == `OFS_LIMIT) begin
         limit_q <= pwdata[WIDTH-1:0]; // [R3]
      end
   end

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         chValueWr[i] = wrEn && regHit(paddr, `OFS_CH_VALUE, i);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            modeField_q[i] <= 2'h0;
            action_q[i] <= `ACT_NONE;
         end
         toggle_q <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (wrEn && regHit(paddr, `OFS_CH_CTRL, i)) begin
               modeField_q[i] <= pwdata[`CH_MODE_HI:`CH_MODE_LO]; // [R16]
               action_q[i] <= pwdata[`CH_ACT_HI:`CH_ACT_LO]; // [R18]
               toggle_q[i] <= pwdata[`CH_TOGGLE]; // [R1]
            end
         end
      end
   end

   // Value writes land at once, even mid period.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < CHANNELS; i++) begin
            value_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (chValueWr[i]) begin
               value_q[i] <= pwdata[WIDTH-1:0]; // [R5]
            end
         end
      end
   end

   // A compare wins over a software clear in the same cycle.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chFlag_q <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (chMatch[i]) begin
               chFlag_q[i] <= 1'b1; // [R2]
            end else if (wrEn && regHit(paddr, `OFS_CH_CTRL, i) &&
               !pwdata[`CH_FLAG]) begin
               chFlag_q[i] <= 1'b0;
            end
         end
      end
   end

   // Tracks which member of each pair was written last.
   always_comb begin
      for (int p = 0; p < PAIRS; p++) begin
         pairBuffered[p] = modeField_q[2*p][`MODE_BUF_BIT]; // [R9] [R21]
         if (chValueWr[2*p+1]) begin
            lastOdd_d[p] = 1'b1; // [R10]
         end else if (chValueWr[2*p]) begin
            lastOdd_d[p] = 1'b0; // [R10]
         end else begin
            lastOdd_d[p] = lastOdd_q[p];
         end
      end
   end

   // The controlling member changes only at an overflow; leaving buffered mode resets it to even at once.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lastOdd_q <= '0;
         activeOdd_q <= '0;
      end else begin
         for (int p = 0; p < PAIRS; p++) begin
            if (!pairBuffered[p]) begin
               lastOdd_q[p] <= 1'b0; // [R9]
               activeOdd_q[p] <= 1'b0; // [R9]
            end else begin
               lastOdd_q[p] <= lastOdd_d[p];
               if (overflowEv) begin
                  activeOdd_q[p] <= lastOdd_d[p]; // [R10]
               end
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         chMode[i] = decodeMode(modeField_q[i],
            (i % 2 == 1) && pairBuffered[i/2]); // [R12]
         if (i % 2 == 0 && pairBuffered[i/2] && activeOdd_q[i/2]) begin
            chValue[i] = value_q[i+1]; // [R10]
         end else begin
            chValue[i] = value_q[i]; // [R9]
         end
      end
   end

   for (genvar g = 0; g < CHANNELS; g++) begin : gChan
      pwm_channel #(.WIDTH(WIDTH)) channel (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .bus(cbus),
         .mode(chMode[g]),
         .action(action_q[g]),
         .toggleOnWrap(toggle_q[g]),
         .value(chValue[g]),
         .level(chLevel[g]),
         .matchEv(chMatch[g])
      );
   end

   // Pins follow the channel level one cycle later.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chanPin <= '0;
         chanPinOeN <= '1;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            chanPin[i] <= chLevel[i];
            chanPinOeN[i] <= (chMode[i] == timer_pwm_pkg::MODE_OFF); // [R12]
         end
      end
   end

   // Read data mux; unmapped addresses answer with an error.
   always_comb begin
      rdData = '0;
      rdHit = 1'b0;
      if (paddr == `OFS_CTRL) begin
         rdHit = 1'b1;
         rdData[`CTRL_FLAG] = flag_q;
         rdData[`CTRL_STOP] = stop_q;
         rdData[`CTRL_PSEL_HI:`CTRL_PSEL_LO] = prescaleSel_q; // [R20]
      end else if (paddr == `OFS_LIMIT) begin
         rdHit = 1'b1;
         rdData[WIDTH-1:0] = limit_q;
      end else if (paddr == `OFS_COUNT) begin
         rdHit = 1'b1;
         rdData[WIDTH-1:0] = count_q;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (regHit(paddr, `OFS_CH_CTRL, i)) begin
               rdHit = 1'b1;
               rdData[`CH_FLAG] = chFlag_q[i];
               rdData[`CH_MODE_HI:`CH_MODE_LO] = modeField_q[i];
               rdData[`CH_ACT_HI:`CH_ACT_LO] = action_q[i];
               rdData[`CH_TOGGLE] = toggle_q[i];
               if (i % 2 == 0) begin
                  rdData[`CH_ACTIVE] = activeOdd_q[i/2]; // [R11]
               end
            end else if (regHit(paddr, `OFS_CH_VALUE, i)) begin
               rdHit = 1'b1;
               rdData[WIDTH-1:0] = value_q[i];
            end
         end
      end
   end

   // One wait state: the answer comes in the second access cycle.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rdData;
         pslverr <= !rdHit;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule

/* File: dv/timer_pwm_channels_props.sv */
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"
module timer_pwm_channels_props #(
   parameter int CHANNELS = 6
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [CHANNELS-1:0] chanPin,
   input wire logic [CHANNELS-1:0] chanPinOeN
);
   logic rdDone;
   logic wrDone;
   assign rdDone = psel && pready && !pwrite;
   assign wrDone = psel && penable && pready && pwrite;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   ready_follows_a:
      assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access phase");
   ready_cause_a:
      assert property (pready |-> $past(psel && penable))
      else $error("pready without access phase");
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_with_ready_a:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_data_zero_a:
      assert property (rdDone && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   reset_pins_a:
      assert property ($rose(rst_n) |-> chanPinOeN == '1 && chanPin == '0)
      else $error("pins not released after reset");
   odd_release_a:
      assert property (wrDone && paddr == `OFS_CH_CTRL && pwdata[`CH_MODE_HI]
         |-> ##[1:4] chanPinOeN[1])
      else $error("odd pin of buffered pair still driven");
   clear_reads_zero_a:
      assert property (rdDone && paddr == `OFS_CTRL |-> !prdata[`CTRL_CLEAR])
      else $error("clear bit read as one");
   limit_upper_zero_a:
      assert property (rdDone && paddr == `OFS_LIMIT
         |-> prdata[31:16] == 16'h0)
      else $error("limit upper bits not zero");
   cover property (rdDone && paddr == `OFS_COUNT);
   cover property (pslverr);
   cover property ($rose(chanPinOeN[1]));
endmodule

bind timer_pwm_channels timer_pwm_channels_props #(
   .CHANNELS(CHANNELS)
) u_timer_pwm_channels_props (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .chanPin(chanPin),
   .chanPinOeN(chanPinOeN)
);

/* File: dv/pwm_load_model.sv */
`timescale 1ns/1ps
module pwm_load_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [5:0] chanPin,
   input wire logic [5:0] chanPinOeN,
   input wire logic [2:0] watch,
   input wire logic rearm,
   output logic done,
   output logic [31:0] highCnt,
   output logic [31:0] periodCnt
);
   logic [5:0] pad;
   logic prevLvl;
   logic armed;
   logic [31:0] hi;
   logic [31:0] per;
   assign pad = chanPin & ~chanPinOeN;
   always_ff @(posedge core_clk) begin
      prevLvl <= pad[watch];
      done <= 1'b0;
      if (!rst_n || rearm) begin
         armed <= 1'b0;
         hi <= 32'h0;
         per <= 32'h0;
      end else if (pad[watch] && !prevLvl) begin
         if (armed) begin
            done <= 1'b1;
            highCnt <= hi;
            periodCnt <= per;
         end
         armed <= 1'b1;
         hi <= 32'h1;
         per <= 32'h1;
      end else begin
         hi <= hi + {31'h0, pad[watch]};
         per <= per + 32'h1;
      end
   end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "timer_pwm_defines.svh"
module tb;
   typedef struct {logic [31:0] hi; logic [31:0] per;} note_t;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic rearm, mDone, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mHigh, mPer, lim, sel, a, b, h, rd;
   logic [31:0] v [6];
   logic [5:0] chanPin, chanPinOeN;
   logic [2:0] watch;
   int checked = 0;
   int fail_count = 0;
   note_t notes [$];
   timer_pwm_channels u_timer_pwm_channels (.core_clk(core_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .chanPin(chanPin), .chanPinOeN(chanPinOeN));
   pwm_load_model u_pwm_load_model (.core_clk(core_clk), .rst_n(rst_n),
      .chanPin(chanPin), .chanPinOeN(chanPinOeN), .watch(watch),
      .rearm(rearm), .done(mDone), .highCnt(mHigh), .periodCnt(mPer));
   task results;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fail_count++;
         results;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task rdChk(input logic [11:0] ad, input logic [31:0] e, input logic ee);
      apb(1'b0, ad, 32'h0);
      chk("rdata", e, rd);
      chk("slverr", {31'h0, ee}, {31'h0, err});
   endtask
   task arm(input int ch);
      @(posedge core_clk);
      watch <= 3'(ch);
      rearm <= 1'b1;
      @(posedge core_clk);
      rearm <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
   task expect2(input logic [31:0] hh, input logic [31:0] p);
      int n;
      notes.push_back('{hh, p});
      notes.push_back('{hh, p});
      n = 0;
      while (notes.size() > 0 && n < 9000) begin
         @(posedge core_clk);
         n++;
      end
      if (notes.size() > 0) begin
         fail_count++;
         results;
      end
   endtask
   task waitPin(input int ch, input logic lvl);
      int n;
      n = 0;
      while (chanPin[ch] !== lvl && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      if (chanPin[ch] !== lvl) begin
         fail_count++;
         results;
      end
   endtask
   always @(posedge core_clk) begin
      if (mDone === 1'b1 && notes.size() > 0) begin
         chk("high", notes[0].hi, mHigh);
         chk("period", notes[0].per, mPer);
         void'(notes.pop_front());
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      watch = 3'h0;
      rearm = 1'b0;
      void'($urandom(32'h918FC584));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rdChk(`OFS_CTRL, 32'h20, 1'b0);
      rdChk(`OFS_LIMIT, 32'hFFFF, 1'b0);
      rdChk(`OFS_COUNT, 32'h0, 1'b0);
      rdChk(12'hFFC, 32'h0, 1'b1);
      $display("test reset done");
      wr(`OFS_CTRL, 32'h30);
      rdChk(`OFS_CTRL, 32'h20, 1'b0);
      lim = 8 + $urandom % 8;
      sel = $urandom % 3;
      wr(`OFS_LIMIT, lim);
      for (int i = 0; i < 6; i++) begin
         v[i] = 1 + $urandom % lim;
         wr(`OFS_CH_VALUE + 12'(4 * i), v[i]);
         wr(`OFS_CH_CTRL + 12'(4 * i), i == 5 ? 32'h1E : 32'h1A);
      end
      wr(`OFS_CTRL, sel);
      chk("oen", 32'h0, {26'h0, chanPinOeN});
      for (int i = 0; i < 6; i++) begin
         arm(i);
         h = (i == 5) ? lim + 1 - v[i] : v[i];
         expect2(h << sel, (lim + 1) << sel);
      end
      $display("test unbuffered done");
      wr(`OFS_CTRL, 32'h30);
      wr(`OFS_LIMIT, 32'hFF);
      wr(`OFS_CH_VALUE, 32'h80);
      wr(`OFS_CTRL, 32'h0);
      arm(0);
      expect2(32'd128, 32'd256);
      rdChk(`OFS_CTRL, 32'h80, 1'b0);
      waitPin(0, 1'b1);
      waitPin(0, 1'b0);
      wr(`OFS_CH_VALUE, 32'h40);
      arm(0);
      expect2(32'd64, 32'd256);
      waitPin(0, 1'b0);
      waitPin(0, 1'b1);
      wr(`OFS_CH_VALUE, 32'hC0);
      arm(0);
      expect2(32'd192, 32'd256);
      $display("test duty done");
      a = 1 + $urandom % lim;
      b = a % lim + 1;
      wr(`OFS_CTRL, 32'h30);
      rdChk(`OFS_COUNT, 32'h0, 1'b0);
      wr(`OFS_LIMIT, lim);
      wr(`OFS_CH_VALUE, a);
      wr(`OFS_CH_CTRL, 32'h3A);
      wr(`OFS_CTRL, 32'h0);
      arm(0);
      expect2(a, lim + 1);
      chk("oddoen", 32'h1, {31'h0, chanPinOeN[1]});
      wr(`OFS_CH_VALUE + 12'h4, b);
      arm(0);
      expect2(b, lim + 1);
      rdChk(`OFS_CH_CTRL, 32'hFA, 1'b0);
      wr(`OFS_CH_VALUE, a);
      arm(0);
      expect2(a, lim + 1);
      $display("test buffered done");
      results;
   end
endmodule
